// >>> common/tapx_defs.svh
// Constants for the test access port block: instruction codes, state codes,
// reset values. Assumes it is included by every file that uses them.
`ifndef TAPX_DEFS_SVH
`define TAPX_DEFS_SVH

// Instruction register
`define TAPX_IR_WIDTH      4
`define TAPX_IR_EXTEST     4'h0
`define TAPX_IR_SCAN_N     4'h2
`define TAPX_IR_INTEST     4'hC
`define TAPX_IR_BYPASS     4'hF
`define TAPX_IR_CAPTURE    4'h1
`define TAPX_IR_RESET      4'hF

// Scan chain select
`define TAPX_CHAIN_WIDTH   4
`define TAPX_CHAIN_RESET   4'h0
`define TAPX_CHAIN_INTERN  4'h0

// Controller state codes shown on tap_state_code
`define TAPX_CODE_TLR      4'hF
`define TAPX_CODE_RTI      4'hC
`define TAPX_CODE_SEL_DR   4'h7
`define TAPX_CODE_CAP_DR   4'h6
`define TAPX_CODE_SH_DR    4'h2
`define TAPX_CODE_EX1_DR   4'h1
`define TAPX_CODE_PA_DR    4'h3
`define TAPX_CODE_EX2_DR   4'h0
`define TAPX_CODE_UPD_DR   4'h5
`define TAPX_CODE_SEL_IR   4'h4
`define TAPX_CODE_CAP_IR   4'hE
`define TAPX_CODE_SH_IR    4'hA
`define TAPX_CODE_EX1_IR   4'h9
`define TAPX_CODE_PA_IR    4'hB
`define TAPX_CODE_EX2_IR   4'h8
`define TAPX_CODE_UPD_IR   4'hD

`endif

// >>> common/tapx_pkg.sv
// Types of the test access port block.
// Assumes tapx_defs.svh holds the numeric constants.
package tapx_pkg;

  typedef enum logic [15:0]
  {
    ST_TLR    = 16'h0001,
    ST_RTI    = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR  = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tapx_state_t;

endpackage : tapx_pkg

// >>> src/tapx_sync2.sv
// Two flip-flop level synchroniser.
// Assumes d is quasi-static relative to clk; q is two edges late.
`timescale 1ns/1ps
module tapx_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : tapx_sync2

// >>> src/tapx_rst_sync.sv
// Reset synchroniser: asserts at once, releases two edges after arst falls.
// Assumes arst may be driven from a pin.
`timescale 1ns/1ps
module tapx_rst_sync (
  // Clock
  input  wire logic clk,
  // Reset in and out
  input  wire logic arst,
  output logic      rst
);

  logic hold;

  always_ff @(posedge clk or posedge arst)
  begin
    if (arst)
    begin
      hold <= 1'b1;
      rst  <= 1'b1;
    end
    else
    begin
      hold <= 1'b0;
      rst  <= hold;
    end
  end

endmodule : tapx_rst_sync

// >>> src/tapx_top.sv
// Test access port controller with hooks for external scan chains.
// Assumes the debugger side of the test pins is synchronous to clk, and that
// test_clock is a free or gated clock from the integrating logic.
//
// Function
// - A 4-bit output mirrors the instruction held in the instruction register.
// - That mirror changes only on a falling clk edge while the controller is in Update-DR.
// - A 4-bit output gives the number of the scan chain currently selected.
// - That chain number changes only on a falling test_clock edge after an Update-DR.
// - A serial output carries the bits to be shifted into an external scan chain.
// - The serial return of an external chain is routed out through the one test data output.
// - A 4-bit output encodes the present controller state, updated on the rising edge.
// - The capture flag is high exactly while the controller is in a capture state with chain 0 selected.
// - The update flag is high exactly while the controller is in an update state with chain 0 selected.
// - The capture, shift, update and internal-test flags assert only while chain 0 is selected.
// - While test_reset_n is low the whole test interface including the state machine is reset.
// - clk is the clock of the controller; test logic advances on it qualified by enables.
`timescale 1ns/1ps
`include "tapx_defs.svh"
module tapx_top
  import tapx_pkg::*;
(
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Link clock for the chain number output
  input  wire logic       test_clock,
  // Debugger test pins
  input  wire logic       test_reset_n,
  input  wire logic       test_clock_enable,
  input  wire logic       test_mode_select,
  input  wire logic       test_serial_in,
  output logic            test_serial_out,
  output logic            test_out_enable_n,
  // External scan chain
  output logic            ext_chain_serial_out,
  input  wire logic       ext_chain_serial_return,
  // Status towards added chains
  output logic [3:0]      tap_instr_mirror,
  output logic [3:0]      selected_chain_id,
  output logic [3:0]      tap_state_code,
  output logic            capture_state_flag,
  output logic            shift_state_flag,
  output logic            update_state_flag,
  output logic            internal_test_flag
);

  logic arst;
  logic rst_tap;
  logic rst_link;

  // Either reset source clears everything; release is synchronised per domain
  assign arst = reset | ~test_reset_n;

  tapx_rst_sync u_rst_sys (
    .clk  (clk),
    .arst (arst),
    .rst  (rst_tap)
  );

  tapx_rst_sync u_rst_link (
    .clk  (test_clock),
    .arst (arst),
    .rst  (rst_link)
  );

  tapx_state_t state;
  tapx_state_t next_state;
  logic [3:0]  ir_shift;
  logic [3:0]  next_ir_shift;
  logic [3:0]  ir;
  logic [3:0]  next_ir;
  logic [3:0]  scan_shift;
  logic [3:0]  next_scan_shift;
  logic [3:0]  chain_sel;
  logic [3:0]  next_chain_sel;
  logic        chain_toggle;
  logic        next_chain_toggle;
  logic        bypass_bit;
  logic        next_bypass_bit;
  logic        next_ext_chain_serial_out;
  logic [3:0]  next_tap_state_code;
  logic        next_capture_state_flag;
  logic        next_shift_state_flag;
  logic        next_update_state_flag;
  logic        next_internal_test_flag;
  logic        ext_path;
  logic        chain0_next;

  function automatic logic [3:0] state_code(input tapx_state_t s);
    case (s)
      ST_TLR:    state_code = `TAPX_CODE_TLR;
      ST_RTI:    state_code = `TAPX_CODE_RTI;
      ST_SEL_DR: state_code = `TAPX_CODE_SEL_DR;
      ST_CAP_DR: state_code = `TAPX_CODE_CAP_DR;
      ST_SH_DR:  state_code = `TAPX_CODE_SH_DR;
      ST_EX1_DR: state_code = `TAPX_CODE_EX1_DR;
      ST_PA_DR:  state_code = `TAPX_CODE_PA_DR;
      ST_EX2_DR: state_code = `TAPX_CODE_EX2_DR;
      ST_UPD_DR: state_code = `TAPX_CODE_UPD_DR;
      ST_SEL_IR: state_code = `TAPX_CODE_SEL_IR;
      ST_CAP_IR: state_code = `TAPX_CODE_CAP_IR;
      ST_SH_IR:  state_code = `TAPX_CODE_SH_IR;
      ST_EX1_IR: state_code = `TAPX_CODE_EX1_IR;
      ST_PA_IR:  state_code = `TAPX_CODE_PA_IR;
      ST_EX2_IR: state_code = `TAPX_CODE_EX2_IR;
      ST_UPD_IR: state_code = `TAPX_CODE_UPD_IR;
      default:   state_code = `TAPX_CODE_TLR;
    endcase
  endfunction : state_code

  // External chain owns the data path for both test instructions
  assign ext_path = (ir == `TAPX_IR_INTEST) || (ir == `TAPX_IR_EXTEST);

  // Controller and shift registers, rising edge of clk
  always_comb
  begin
    next_state                = state;
    next_ir_shift             = ir_shift;
    next_ir                   = ir;
    next_scan_shift           = scan_shift;
    next_chain_sel            = chain_sel;
    next_chain_toggle         = chain_toggle;
    next_bypass_bit           = bypass_bit;
    next_ext_chain_serial_out = ext_chain_serial_out;
    if (test_clock_enable)
    begin
      case (state)
        ST_TLR:    next_state = test_mode_select ? ST_TLR    : ST_RTI;
        ST_RTI:    next_state = test_mode_select ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR: next_state = test_mode_select ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: next_state = test_mode_select ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  next_state = test_mode_select ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: next_state = test_mode_select ? ST_UPD_DR : ST_PA_DR;
        ST_PA_DR:  next_state = test_mode_select ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: next_state = test_mode_select ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: next_state = test_mode_select ? ST_SEL_DR : ST_RTI;
        ST_SEL_IR: next_state = test_mode_select ? ST_TLR    : ST_CAP_IR;
        ST_CAP_IR: next_state = test_mode_select ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  next_state = test_mode_select ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: next_state = test_mode_select ? ST_UPD_IR : ST_PA_IR;
        ST_PA_IR:  next_state = test_mode_select ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: next_state = test_mode_select ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: next_state = test_mode_select ? ST_SEL_DR : ST_RTI;
        default:   next_state = ST_TLR;
      endcase
      case (state)
        ST_TLR:    next_ir = `TAPX_IR_RESET;
        ST_CAP_IR: next_ir_shift = `TAPX_IR_CAPTURE;
        ST_SH_IR:  next_ir_shift = {test_serial_in, ir_shift[3:1]};
        ST_UPD_IR: next_ir = ir_shift;
        ST_CAP_DR:
        begin
          next_scan_shift = chain_sel;
          next_bypass_bit = 1'b0;
        end
        ST_SH_DR:
        begin
          next_scan_shift           = {test_serial_in, scan_shift[3:1]};
          next_bypass_bit           = test_serial_in;
          next_ext_chain_serial_out = test_serial_in;
        end
        ST_UPD_DR:
        begin
          if (ir == `TAPX_IR_SCAN_N)
          begin
            next_chain_sel    = scan_shift;
            next_chain_toggle = ~chain_toggle;
          end
        end
        default:
        begin
          next_ir = ir;
        end
      endcase
    end
  end

  // Flags follow the registered state, so they are computed from its next value
  always_comb
  begin
    chain0_next             = (next_chain_sel == `TAPX_CHAIN_INTERN);
    next_tap_state_code     = state_code(next_state);
    next_capture_state_flag = chain0_next && (next_state == ST_CAP_DR || next_state == ST_CAP_IR);
    next_shift_state_flag   = chain0_next && (next_state == ST_SH_DR || next_state == ST_SH_IR);
    next_update_state_flag  = chain0_next && (next_state == ST_UPD_DR || next_state == ST_UPD_IR);
    next_internal_test_flag = chain0_next && (next_ir == `TAPX_IR_INTEST);
  end

  always_ff @(posedge clk or posedge rst_tap)
  begin
    if (rst_tap)
    begin
      state                <= ST_TLR;
      ir_shift             <= `TAPX_IR_RESET;
      ir                   <= `TAPX_IR_RESET;
      scan_shift           <= `TAPX_CHAIN_RESET;
      chain_sel            <= `TAPX_CHAIN_RESET;
      chain_toggle         <= 1'b0;
      bypass_bit           <= 1'b0;
      ext_chain_serial_out <= 1'b0;
      tap_state_code       <= `TAPX_CODE_TLR;
      capture_state_flag   <= 1'b0;
      shift_state_flag     <= 1'b0;
      update_state_flag    <= 1'b0;
      internal_test_flag   <= 1'b0;
    end
    else
    begin
      state                <= next_state;
      ir_shift             <= next_ir_shift;
      ir                   <= next_ir;
      scan_shift           <= next_scan_shift;
      chain_sel            <= next_chain_sel;
      chain_toggle         <= next_chain_toggle;
      bypass_bit           <= next_bypass_bit;
      ext_chain_serial_out <= next_ext_chain_serial_out;
      tap_state_code       <= next_tap_state_code;
      capture_state_flag   <= next_capture_state_flag;
      shift_state_flag     <= next_shift_state_flag;
      update_state_flag    <= next_update_state_flag;
      internal_test_flag   <= next_internal_test_flag;
    end
  end

  // Falling edge of clk: data out and instruction mirror
  logic [3:0] next_tap_instr_mirror;
  logic       next_test_serial_out;
  logic       next_test_out_enable_n;

  always_comb
  begin
    next_tap_instr_mirror = tap_instr_mirror;
    if (state == ST_UPD_DR)
    begin
      next_tap_instr_mirror = ir;
    end
    next_test_out_enable_n = !(state == ST_SH_DR || state == ST_SH_IR);
    next_test_serial_out   = 1'b0;
    if (state == ST_SH_IR)
    begin
      next_test_serial_out = ir_shift[0];
    end
    else if (state == ST_SH_DR)
    begin
      if (ir == `TAPX_IR_SCAN_N)
      begin
        next_test_serial_out = scan_shift[0];
      end
      else if (ext_path)
      begin
        next_test_serial_out = ext_chain_serial_return;
      end
      else
      begin
        next_test_serial_out = bypass_bit;
      end
    end
  end

  always_ff @(negedge clk or posedge rst_tap)
  begin
    if (rst_tap)
    begin
      tap_instr_mirror  <= `TAPX_IR_RESET;
      test_serial_out   <= 1'b0;
      test_out_enable_n <= 1'b1;
    end
    else
    begin
      tap_instr_mirror  <= next_tap_instr_mirror;
      test_serial_out   <= next_test_serial_out;
      test_out_enable_n <= next_test_out_enable_n;
    end
  end

  // Link domain: chain number handed over by toggle; chain_sel is held stable
  // while the toggle crosses, so back-to-back Update-DRs closer than a few
  // test_clock periods would be merged into the later value.
  logic       toggle_link;
  logic       toggle_seen;
  logic       next_toggle_seen;
  logic       chain_load;
  logic [3:0] next_selected_chain_id;

  tapx_sync2 #(
    .WIDTH (1)
  ) u_toggle_sync (
    .clk (test_clock),
    .rst (rst_link),
    .d   (chain_toggle),
    .q   (toggle_link)
  );

  always_comb
  begin
    chain_load             = (toggle_link != toggle_seen);
    next_toggle_seen       = toggle_link;
    next_selected_chain_id = chain_load ? chain_sel : selected_chain_id;
  end

  always_ff @(negedge test_clock or posedge rst_link)
  begin
    if (rst_link)
    begin
      toggle_seen       <= 1'b0;
      selected_chain_id <= `TAPX_CHAIN_RESET;
    end
    else
    begin
      toggle_seen       <= next_toggle_seen;
      selected_chain_id <= next_selected_chain_id;
    end
  end

  // Checks
  a_state_hold: assert property (@(posedge clk) disable iff (rst_tap)
    !test_clock_enable |=> $stable(state))
    else $error("State moved without test clock enable");

  a_code_follows: assert property (@(posedge clk) disable iff (rst_tap)
    (test_clock_enable && state == ST_TLR && !test_mode_select) |=> tap_state_code == `TAPX_CODE_RTI)
    else $error("State code did not follow leaving reset state");

  a_capture_flag: assert property (@(posedge clk) disable iff (rst_tap)
    capture_state_flag == ((state == ST_CAP_DR || state == ST_CAP_IR) && chain_sel == `TAPX_CHAIN_INTERN))
    else $error("Capture flag mismatch");

  a_shift_flag: assert property (@(posedge clk) disable iff (rst_tap)
    shift_state_flag == ((state == ST_SH_DR || state == ST_SH_IR) && chain_sel == `TAPX_CHAIN_INTERN))
    else $error("Shift flag mismatch");

  a_update_flag: assert property (@(posedge clk) disable iff (rst_tap)
    update_state_flag == ((state == ST_UPD_DR || state == ST_UPD_IR) && chain_sel == `TAPX_CHAIN_INTERN))
    else $error("Update flag mismatch");

  a_intest_flag: assert property (@(posedge clk) disable iff (rst_tap)
    internal_test_flag == (ir == `TAPX_IR_INTEST && chain_sel == `TAPX_CHAIN_INTERN))
    else $error("Internal test flag mismatch");

  a_flag_chain0: assert property (@(posedge clk) disable iff (rst_tap)
    (chain_sel != `TAPX_CHAIN_INTERN) |-> !internal_test_flag && !shift_state_flag)
    else $error("Flag active with nonzero chain");

  // Enable is launched on the falling edge, so it matches the state held since the last rising edge
  a_out_enable: assert property (@(posedge clk) disable iff (rst_tap)
    !test_out_enable_n == (state == ST_SH_DR || state == ST_SH_IR))
    else $error("Output enable not tied to shift state");

  a_mirror_upd: assert property (@(posedge clk) disable iff (rst_tap)
    $changed(tap_instr_mirror) |-> state == ST_UPD_DR)
    else $error("Instruction mirror changed outside Update-DR");

  a_ext_serial: assert property (@(posedge clk) disable iff (rst_tap)
    (test_clock_enable && state == ST_SH_DR) |=> ext_chain_serial_out == $past(test_serial_in))
    else $error("External chain serial out did not follow input");

  a_chain_load: assert property (@(negedge test_clock) disable iff (rst_link)
    $changed(selected_chain_id) |-> $past(chain_load))
    else $error("Chain number changed without an update");

endmodule : tapx_top

// >>> testbench/tapx_ext_chain.sv
// Model of an external scan chain hung on the test port.
// Assumes it shares clk with the port and follows its state code.
`timescale 1ns/1ps
`include "tapx_defs.svh"
module tapx_ext_chain
  import tapx_pkg::*;
#(
  parameter logic [3:0] PRESET = 4'h6
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Port side
  input  wire logic       test_clock_enable,
  input  wire logic [3:0] tap_state_code,
  input  wire logic       ext_chain_serial_out,
  // Bench control and return
  input  wire logic       attached,
  output logic            ext_chain_serial_return
);
  logic [3:0] chain;
  logic [3:0] next_chain;

  always_comb
  begin
    next_chain = chain;
    if (test_clock_enable)
    begin
      if (tap_state_code == `TAPX_CODE_CAP_DR)
        next_chain = PRESET;
      else if (tap_state_code == `TAPX_CODE_SH_DR)
        next_chain = {ext_chain_serial_out, chain[3:1]};
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      chain <= 4'h0;
    else
      chain <= next_chain;
  end

  // A missing chain must read as low, never as a stale bit
  assign ext_chain_serial_return = attached ? chain[0] : 1'b0;
endmodule : tapx_ext_chain

// >>> testbench/tapx_top_tb.sv
// Self-checking bench for the test access port block.
// Assumes the debugger pins are driven on the falling clk edge.
`timescale 1ns/1ps
`include "tapx_defs.svh"
module tapx_top_tb;
  import tapx_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic test_clock = 1'b0;
  logic test_reset_n = 1'b1;
  logic test_clock_enable = 1'b0;
  logic test_mode_select = 1'b1;
  logic test_serial_in = 1'b0;
  logic attached = 1'b0;
  logic test_serial_out, test_out_enable_n, ext_chain_serial_out, ext_chain_serial_return;
  logic capture_state_flag, shift_state_flag, update_state_flag, internal_test_flag;
  logic [3:0] tap_instr_mirror, selected_chain_id, tap_state_code, seen;
  logic tdo_seen, oe_seen;
  int fails = 0;
  int check_count = 0;

  always #5 clk = ~clk;
  // Link clock unrelated in phase to clk
  always #3 test_clock = ~test_clock;

  tapx_top tapx_top_inst (.clk(clk), .reset(reset), .test_clock(test_clock), .test_reset_n(test_reset_n),
    .test_clock_enable(test_clock_enable), .test_mode_select(test_mode_select), .test_serial_in(test_serial_in),
    .test_serial_out(test_serial_out), .test_out_enable_n(test_out_enable_n),
    .ext_chain_serial_out(ext_chain_serial_out), .ext_chain_serial_return(ext_chain_serial_return),
    .tap_instr_mirror(tap_instr_mirror), .selected_chain_id(selected_chain_id), .tap_state_code(tap_state_code),
    .capture_state_flag(capture_state_flag), .shift_state_flag(shift_state_flag),
    .update_state_flag(update_state_flag), .internal_test_flag(internal_test_flag));

  tapx_ext_chain tapx_ext_chain_inst (.clk(clk), .reset(reset | ~test_reset_n),
    .test_clock_enable(test_clock_enable), .tap_state_code(tap_state_code),
    .ext_chain_serial_out(ext_chain_serial_out), .attached(attached),
    .ext_chain_serial_return(ext_chain_serial_return));

  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // One enabled clock; tdo and oe_n are read after the falling edge
  task automatic step(input logic tms, input logic tdi);
    @(negedge clk);
    test_mode_select <= tms;
    test_serial_in <= tdi;
    test_clock_enable <= 1'b1;
    #1;
    tdo_seen = test_serial_out;
    oe_seen = test_out_enable_n;
    @(posedge clk);
    #1;
  endtask : step

  task automatic ir_scan(input logic [3:0] v, input logic fl);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    check("ir capture flag", {3'b0, fl}, {3'b0, capture_state_flag});
    step(1'b0, 1'b0);
    check("ir shift flag", {3'b0, fl}, {3'b0, shift_state_flag});
    for (int i = 0; i < 4; i++)
      step(i == 3, v[i]);
    step(1'b1, 1'b0);
    check("ir update flag", {3'b0, fl}, {3'b0, update_state_flag});
    step(1'b0, 1'b0);
    check("idle code", `TAPX_CODE_RTI, tap_state_code);
  endtask : ir_scan

  task automatic dr_scan(input logic [3:0] d, input logic fl, output logic [3:0] got);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    check("dr capture flag", {3'b0, fl}, {3'b0, capture_state_flag});
    step(1'b0, 1'b0);
    check("dr shift flag", {3'b0, fl}, {3'b0, shift_state_flag});
    for (int i = 0; i < 4; i++)
    begin
      step(i == 3, d[i]);
      got[i] = tdo_seen;
      check("oe_n in shift", 4'h0, {3'b0, oe_seen});
      check("chain serial out", {3'b0, d[i]}, {3'b0, ext_chain_serial_out});
    end
    step(1'b1, 1'b0);
    check("oe_n after shift", 4'h1, {3'b0, oe_seen});
    check("dr update flag", {3'b0, fl}, {3'b0, update_state_flag});
    step(1'b0, 1'b0);
  endtask : dr_scan

  task automatic reset_values();
    check("reset code", `TAPX_CODE_TLR, tap_state_code);
    check("reset mirror", `TAPX_IR_RESET, tap_instr_mirror);
    check("reset oe_n", 4'h1, {3'b0, test_out_enable_n});
    check("reset flags", 4'h0, {capture_state_flag, shift_state_flag, update_state_flag, internal_test_flag});
  endtask : reset_values

  task automatic select_chain(input logic [3:0] id, input logic fl, input logic [3:0] old_id);
    ir_scan(`TAPX_IR_SCAN_N, fl);
    dr_scan(id, fl, seen);
    check("captured chain", old_id, seen);
    check("mirror scan_n", `TAPX_IR_SCAN_N, tap_instr_mirror);
    repeat (10) @(posedge clk);
    check("chain id", id, selected_chain_id);
  endtask : select_chain

  initial
  begin
    #100000;
    fails++;
    end_sim();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    reset_values();
    check("reset chain id", `TAPX_CHAIN_RESET, selected_chain_id);
    step(1'b0, 1'b0);
    check("idle code", `TAPX_CODE_RTI, tap_state_code);
    // Enable low: a stream of ones must not move the controller
    @(negedge clk);
    test_clock_enable <= 1'b0;
    test_mode_select <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check("held code", `TAPX_CODE_RTI, tap_state_code);
    ir_scan(`TAPX_IR_SCAN_N, 1'b1);
    check("mirror before dr update", `TAPX_IR_RESET, tap_instr_mirror);
    dr_scan(4'h3, 1'b1, seen);
    check("captured chain", 4'h0, seen);
    check("mirror after dr update", `TAPX_IR_SCAN_N, tap_instr_mirror);
    repeat (10) @(posedge clk);
    check("chain id", 4'h3, selected_chain_id);
    // Chain 3 selected: every flag stays quiet
    attached <= 1'b1;
    ir_scan(`TAPX_IR_INTEST, 1'b0);
    dr_scan(4'h5, 1'b0, seen);
    check("ext return", 4'h6, seen);
    check("intest flag off", 4'h0, {3'b0, internal_test_flag});
    select_chain(4'h0, 1'b0, 4'h3);
    // Chain 0 again with no chain attached: return reads low
    attached <= 1'b0;
    ir_scan(`TAPX_IR_INTEST, 1'b1);
    dr_scan(4'h9, 1'b1, seen);
    check("detached return", 4'h0, seen);
    check("intest flag on", 4'h1, {3'b0, internal_test_flag});
    attached <= 1'b1;
    ir_scan(`TAPX_IR_EXTEST, 1'b1);
    dr_scan(4'hA, 1'b1, seen);
    check("extest return", 4'h6, seen);
    check("mirror extest", `TAPX_IR_EXTEST, tap_instr_mirror);
    // Test reset in mid-run
    @(negedge clk);
    test_reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    reset_values();
    @(negedge clk);
    test_reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    step(1'b0, 1'b0);
    check("idle after test reset", `TAPX_CODE_RTI, tap_state_code);
    end_sim();
  end
endmodule : tapx_top_tb
